// ==== inc/link_ctrl_pkg.sv ====
// constants for the converter configuration register bank
// assumes byte addresses on the register bus are four times the register index

package link_ctrl_pkg;

  // ************************************************************
  // register indexes and bus addressing
  // ************************************************************
  localparam int        ADDR_W        = 12;
  localparam logic [11:0] IDX_DITHER    = 12'h09D;
  localparam logic [11:0] IDX_TS_LSB    = 12'h160;
  localparam logic [11:0] IDX_MISC      = 12'h161;
  localparam logic [11:0] IDX_LINK_EN   = 12'h200;
  localparam logic [11:0] IDX_LINK_MODE = 12'h201;
  localparam logic [11:0] IDX_KM        = 12'h202;
  localparam logic [11:0] IDX_MODE_LOCK = 12'h20E;
  localparam logic [11:0] IDX_STATUS    = 12'h20F;

  // ************************************************************
  // reset values and field positions
  // ************************************************************
  localparam logic [7:0] RST_DITHER    = 8'h01;
  localparam logic [7:0] RST_TS_LSB    = 8'h00;
  localparam logic [7:0] RST_MISC      = 8'h00;
  localparam logic [7:0] RST_LINK_EN   = 8'h01;
  localparam logic [7:0] RST_LINK_MODE = 8'h02;
  localparam logic [7:0] RST_KM        = 8'h1F;
  localparam logic [7:0] RST_MODE_LOCK = 8'hFF;

  localparam int DITH_EN_BIT  = 0;
  localparam int DITH_AMP_BIT = 1;
  localparam int DITH_ERR_BIT = 2;
  localparam int TS_EN_BIT    = 0;
  localparam int TSRX_BIT     = 0;
  localparam int CAL_EN_BIT   = 1;
  localparam int LINK_EN_BIT  = 0;

  // ************************************************************
  // timing and protocol
  // ************************************************************
  localparam int          SYNC_STAGES = 2;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  function automatic logic [ADDR_W-1:0] byte_addr(input logic [11:0] idx);
    byte_addr = {idx[ADDR_W-3:0], 2'h0};
  endfunction

endpackage

// ==== hw/sample_delay_line.sv ====
// fixed-latency delay line for sample words
// assumes one word enters on every clock edge
`timescale 1ns/1ps

module sample_delay_line #(
  parameter int W     = 14,
  parameter int DEPTH = 4
) (
  input  wire logic         clk,
  input  wire logic         sys_rst,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);

  logic [W-1:0] stage [DEPTH];

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      for (int i = 0; i < DEPTH; i++) begin
        stage[i] <= '0;
      end
    end else begin
      stage[0] <= din;
      for (int i = 1; i < DEPTH; i++) begin
        stage[i] <= stage[i-1];
      end
    end
  end

  // the delayed word leaves straight from the last register
  assign dout = stage[DEPTH-1];

endmodule

// ==== hw/axil_reg_slave.sv ====
// AXI4-Lite slave front end for an 8-bit register file
// assumes the register file decodes addresses combinationally
`timescale 1ns/1ps

module axil_reg_slave
  import link_ctrl_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              sys_rst,
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  output logic                   wr_en,
  output logic [ADDR_W-1:0]      wr_addr,
  output logic [7:0]             wr_data,
  output logic                   wr_lane0,
  input  wire logic              wr_ok,
  output logic [ADDR_W-1:0]      rd_addr,
  input  wire logic [7:0]        rd_data,
  input  wire logic              rd_ok
);

  logic aw_held;
  logic w_held;

  // address and data are parked separately, so either may come first
  assign awready = !aw_held && !bvalid;
  assign wready  = !w_held && !bvalid;
  assign wr_en   = aw_held && w_held && !bvalid;
  assign arready = !rvalid;
  assign rd_addr = araddr;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      aw_held  <= 1'b0;
      w_held   <= 1'b0;
      wr_addr  <= '0;
      wr_data  <= 8'h00;
      wr_lane0 <= 1'b0;
      bvalid   <= 1'b0;
      bresp    <= RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        aw_held <= 1'b1;
        wr_addr <= awaddr;
      end
      if (wvalid && wready) begin
        w_held   <= 1'b1;
        wr_data  <= wdata[7:0];
        wr_lane0 <= wstrb[0];
      end
      if (wr_en) begin
        aw_held <= 1'b0;
        w_held  <= 1'b0;
        bvalid  <= 1'b1;
        bresp   <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rvalid <= 1'b0;
      rdata  <= 32'h0000_0000;
      rresp  <= RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rdata  <= {24'h00_0000, rd_ok ? rd_data : 8'h00};
      rresp  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end

endmodule

// ==== hw/adc_dither_timestamp_link_ctrl.sv ====
// configuration registers for dither, timestamp marking and link enable/mode
// assumes samples and mode decode arrive on clk; timestamp pin is asynchronous
//
// Operation
// - error select: zero costs SNR, one costs offset
// - amplitude bit: zero small dither, one large
// - dither enable bit, reset one, turns dither
// - timestamp enable puts marker in sample LSB
// - marker delayed exactly like the samples
// - 8-bit mode: marker in LSB, seven data
// - 12-bit mode: marker in LSB, eleven data
// - alignment sequence always advertises zero control bits
// - link enable, reset one, gates output interface
// - link off: reset, serializers down, clocks gated
// - link off: multiframe counter held in reset
// - 8-bit mode field, reset 0x02, selects mode
// - mode-lock register limits selectable modes
// - frames-per-multiframe resets to 0x1F
// - frames-per-multiframe register holds K minus one
// - 64b/66b modes derive K from mode
//
// Decided for this implementation: the AXI4-Lite slave port.
`timescale 1ns/1ps

module adc_dither_timestamp_link_ctrl
  import link_ctrl_pkg::*;
#(
  parameter int          SAMPLE_W       = 12,
  parameter int          SAMPLE_LATENCY = 4,
  parameter logic [7:0]  FIRST_64B_MODE = 8'h20
) (
  input  wire logic                clk,
  input  wire logic                sys_rst,
  input  wire logic [ADDR_W-1:0]   s_axi_awaddr,
  input  wire logic                s_axi_awvalid,
  output logic                     s_axi_awready,
  input  wire logic [31:0]         s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  input  wire logic                s_axi_wvalid,
  output logic                     s_axi_wready,
  output logic [1:0]               s_axi_bresp,
  output logic                     s_axi_bvalid,
  input  wire logic                s_axi_bready,
  input  wire logic [ADDR_W-1:0]   s_axi_araddr,
  input  wire logic                s_axi_arvalid,
  output logic                     s_axi_arready,
  output logic [31:0]              s_axi_rdata,
  output logic [1:0]               s_axi_rresp,
  output logic                     s_axi_rvalid,
  input  wire logic                s_axi_rready,
  input  wire logic [SAMPLE_W-1:0] sample_in,
  input  wire logic                sample_in_valid,
  input  wire logic                sample_is_8bit,
  input  wire logic                timestamp_pin,
  input  wire logic [7:0]          k_from_mode_m1,
  output logic [SAMPLE_W-1:0]      sample_out,
  output logic                     sample_out_valid,
  output logic                     dither_enable,
  output logic                     dither_amplitude_sel,
  output logic                     dither_round_error_sel,
  output logic                     timestamp_receiver_enable,
  output logic                     cal_enable,
  output logic                     link_block_reset,
  output logic                     serializer_power_down,
  output logic                     link_clock_enable,
  output logic                     multiframe_counter_reset,
  output logic [7:0]               link_mode_select,
  output logic [7:0]               frames_per_multiframe_eff,
  output logic [1:0]               ila_control_bits
);
  default clocking cb_main @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  // ************************************************************
  // register bus front end
  // ************************************************************
  logic              wr_en;
  logic [ADDR_W-1:0] wr_addr;
  logic [7:0]        wr_data;
  logic              wr_lane0;
  logic              wr_ok;
  logic [ADDR_W-1:0] rd_addr;
  logic [7:0]        rd_data;
  logic              rd_ok;

  axil_reg_slave axil_reg_slave_inst (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .awaddr   (s_axi_awaddr),
    .awvalid  (s_axi_awvalid),
    .awready  (s_axi_awready),
    .wdata    (s_axi_wdata),
    .wstrb    (s_axi_wstrb),
    .wvalid   (s_axi_wvalid),
    .wready   (s_axi_wready),
    .bresp    (s_axi_bresp),
    .bvalid   (s_axi_bvalid),
    .bready   (s_axi_bready),
    .araddr   (s_axi_araddr),
    .arvalid  (s_axi_arvalid),
    .arready  (s_axi_arready),
    .rdata    (s_axi_rdata),
    .rresp    (s_axi_rresp),
    .rvalid   (s_axi_rvalid),
    .rready   (s_axi_rready),
    .wr_en    (wr_en),
    .wr_addr  (wr_addr),
    .wr_data  (wr_data),
    .wr_lane0 (wr_lane0),
    .wr_ok    (wr_ok),
    .rd_addr  (rd_addr),
    .rd_data  (rd_data),
    .rd_ok    (rd_ok)
  );

  // ************************************************************
  // register file
  // ************************************************************
  logic [7:0] dither_ctrl;
  logic [7:0] ts_mark_ctrl;
  logic [7:0] misc_ctrl;
  logic [7:0] link_en_reg;
  logic [7:0] link_mode_reg;
  logic [7:0] km_reg;
  logic [7:0] mode_lock;
  logic [7:0] status;

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [11:0] idx);
    hit = (a == byte_addr(idx));
  endfunction

  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    mapped = hit(a, IDX_DITHER) || hit(a, IDX_TS_LSB) || hit(a, IDX_MISC) ||
             hit(a, IDX_LINK_EN) || hit(a, IDX_LINK_MODE) || hit(a, IDX_KM) ||
             hit(a, IDX_MODE_LOCK) || hit(a, IDX_STATUS);
  endfunction

  wire wr_go        = wr_en && wr_lane0;
  wire wr_dither    = wr_go && hit(wr_addr, IDX_DITHER);
  wire wr_ts        = wr_go && hit(wr_addr, IDX_TS_LSB);
  wire wr_misc      = wr_go && hit(wr_addr, IDX_MISC);
  wire wr_link_en   = wr_go && hit(wr_addr, IDX_LINK_EN);
  wire wr_mode      = wr_go && hit(wr_addr, IDX_LINK_MODE);
  wire wr_km        = wr_go && hit(wr_addr, IDX_KM);
  wire wr_lock      = wr_go && hit(wr_addr, IDX_MODE_LOCK);
  // modes above the lock ceiling are dropped silently; bus still answers okay
  wire mode_allowed = (wr_data <= mode_lock);

  // status is read-only; writes to it are accepted and discarded
  assign wr_ok = mapped(wr_addr);
  assign rd_ok = mapped(rd_addr);

  assign rd_data = hit(rd_addr, IDX_DITHER)    ? dither_ctrl   :
                   hit(rd_addr, IDX_TS_LSB)    ? ts_mark_ctrl  :
                   hit(rd_addr, IDX_MISC)      ? misc_ctrl     :
                   hit(rd_addr, IDX_LINK_EN)   ? link_en_reg   :
                   hit(rd_addr, IDX_LINK_MODE) ? link_mode_reg :
                   hit(rd_addr, IDX_KM)        ? km_reg        :
                   hit(rd_addr, IDX_MODE_LOCK) ? mode_lock     :
                   hit(rd_addr, IDX_STATUS)    ? status        : 8'h00;

  // whole bytes are stored, so reserved bits read back as written
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      dither_ctrl   <= RST_DITHER;
      ts_mark_ctrl  <= RST_TS_LSB;
      misc_ctrl     <= RST_MISC;
      link_en_reg   <= RST_LINK_EN;
      link_mode_reg <= RST_LINK_MODE;
      km_reg        <= RST_KM;
      mode_lock     <= RST_MODE_LOCK;
    end else begin
      if (wr_dither) begin
        dither_ctrl <= wr_data;
      end
      if (wr_ts) begin
        ts_mark_ctrl <= wr_data;
      end
      if (wr_misc) begin
        misc_ctrl <= wr_data;
      end
      if (wr_link_en) begin
        link_en_reg <= wr_data;
      end
      // ordering against link/calibration enable is software's duty
      if (wr_mode && mode_allowed) begin
        link_mode_reg <= wr_data;
      end
      if (wr_km) begin
        km_reg <= wr_data;
      end
      if (wr_lock) begin
        mode_lock <= wr_data;
      end
    end
  end

  // ************************************************************
  // control outputs
  // ************************************************************
  wire link_on  = link_en_reg[LINK_EN_BIT];
  wire ts_on    = ts_mark_ctrl[TS_EN_BIT];
  wire mode_64b = (link_mode_reg >= FIRST_64B_MODE);

  assign dither_enable             = dither_ctrl[DITH_EN_BIT];
  assign dither_amplitude_sel      = dither_ctrl[DITH_AMP_BIT];
  assign dither_round_error_sel    = dither_ctrl[DITH_ERR_BIT];
  assign timestamp_receiver_enable = misc_ctrl[TSRX_BIT];
  assign cal_enable                = misc_ctrl[CAL_EN_BIT];
  assign link_clock_enable         = link_on;
  assign link_block_reset          = !link_on;
  assign serializer_power_down     = !link_on;
  // a held counter ignores sysref, so no alignment while off
  assign multiframe_counter_reset  = !link_on;
  assign link_mode_select          = link_mode_reg;
  assign frames_per_multiframe_eff = mode_64b ? k_from_mode_m1 : km_reg;
  // the inserted marker is never announced in the lane alignment data
  assign ila_control_bits          = 2'h0;

  // ************************************************************
  // timestamp marking
  // ************************************************************
  logic [SYNC_STAGES-1:0] ts_sync;
  logic [SAMPLE_W-1:0]    smp_d [SYNC_STAGES];
  logic [SYNC_STAGES-1:0] vld_d;
  logic [SAMPLE_W+1:0]    dl_out;
  logic [SAMPLE_W-1:0]    dl_smp;
  logic [SAMPLE_W-1:0]    next_sample;

  // samples wait as long as the pin synchroniser, keeping marks aligned
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ts_sync <= '0;
      vld_d   <= '0;
      for (int i = 0; i < SYNC_STAGES; i++) begin
        smp_d[i] <= '0;
      end
    end else begin
      ts_sync  <= {ts_sync[SYNC_STAGES-2:0], timestamp_pin};
      vld_d    <= {vld_d[SYNC_STAGES-2:0], sample_in_valid};
      smp_d[0] <= sample_in;
      for (int i = 1; i < SYNC_STAGES; i++) begin
        smp_d[i] <= smp_d[i-1];
      end
    end
  end

  wire ts_now = ts_sync[SYNC_STAGES-1];

  sample_delay_line #(
    .W     (SAMPLE_W + 2),
    .DEPTH (SAMPLE_LATENCY)
  ) sample_delay_line_inst (
    .clk     (clk),
    .sys_rst (sys_rst),
    .din     ({vld_d[SYNC_STAGES-1], ts_now, smp_d[SYNC_STAGES-1]}),
    .dout    (dl_out)
  );

  assign dl_smp = dl_out[SAMPLE_W-1:0];

  // 8-bit samples ride in the low byte; upper bits are zero
  always_comb begin
    next_sample = dl_smp;
    if (sample_is_8bit) begin
      next_sample = {{(SAMPLE_W-8){1'b0}}, dl_smp[7:0]};
      if (ts_on) begin
        next_sample[0] = dl_out[SAMPLE_W];
      end
    end else if (ts_on) begin
      next_sample[0] = dl_out[SAMPLE_W];
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sample_out       <= '0;
      sample_out_valid <= 1'b0;
    end else begin
      sample_out       <= next_sample;
      sample_out_valid <= dl_out[SAMPLE_W+1];
    end
  end

  assign status = {4'h0, ts_now, mode_64b, ts_on & !timestamp_receiver_enable, link_on};

  // ************************************************************
  // checks
  // ************************************************************
  sequence s_link_write(logic v);
    wr_link_en && (wr_data[LINK_EN_BIT] == v);
  endsequence
  sequence s_link_held;
    link_block_reset && serializer_power_down && !link_clock_enable;
  endsequence
  chk_dither_enable: assert property (
    wr_dither |=> dither_enable == $past(wr_data[DITH_EN_BIT]))
    else $error("dither enable does not follow write");
  chk_dither_amp: assert property (
    wr_dither ##1 !wr_dither |=> dither_amplitude_sel == $past(wr_data[DITH_AMP_BIT], 2))
    else $error("dither amplitude lost");
  chk_dither_round: assert property (
    !wr_dither |=> $stable(dither_round_error_sel))
    else $error("round error select moved without write");
  chk_link_off_hold: assert property (
    s_link_write(1'b0) |=> s_link_held [*2] or (s_link_held ##1 wr_link_en))
    else $error("link not held after disable");
  chk_link_on_run: assert property (
    s_link_write(1'b1) |=> link_clock_enable && !multiframe_counter_reset)
    else $error("link not enabled by write");
  chk_mfc_reset: assert property (
    multiframe_counter_reset && !(wr_link_en && wr_data[LINK_EN_BIT]) |=> multiframe_counter_reset)
    else $error("multiframe counter freed without enable write");
  chk_ila_cs: assert property (
    ts_on |-> ila_control_bits == 2'h0)
    else $error("control bits advertised");
  chk_ts_lsb: assert property (
    $past(ts_on) && sample_out_valid
      |-> sample_out[0] == $past(ts_now, SAMPLE_LATENCY + 1))
    else $error("timestamp not aligned with sample");
  chk_ts_8bit: assert property (
    $past(sample_is_8bit) |-> sample_out[SAMPLE_W-1:8] == '0)
    else $error("8-bit sample spills above low byte");
  chk_mode_lock: assert property (
    wr_mode && (wr_data > mode_lock) |=> $stable(link_mode_select))
    else $error("locked mode accepted");
  chk_k_select: assert property (
    mode_64b |-> frames_per_multiframe_eff == k_from_mode_m1)
    else $error("register K used in 64b/66b mode");
  chk_km_reset: assert property (
    $fell(sys_rst) |-> km_reg == 8'h1F && link_mode_select == 8'h02)
    else $error("reset value wrong");
endmodule

// ==== tb/adc_dither_timestamp_link_ctrl_test.sv ====
// self-checking bench for the converter configuration register bank
// assumes link_ctrl_pkg is compiled first; the bench is the only bus master
`timescale 1ns/1ps

module adc_dither_timestamp_link_ctrl_test;
  import link_ctrl_pkg::*;

  // ************************************************************
  // stimulus and design
  // ************************************************************
  logic              clk = 1'b0;
  logic              sys_rst = 1'b1;
  logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic              s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic              s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [31:0]       s_axi_wdata = '0;
  logic [3:0]        s_axi_wstrb = 4'hF;
  logic              s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]        s_axi_bresp, s_axi_rresp, ila_control_bits;
  logic [31:0]       s_axi_rdata;
  logic [11:0]       sample_in = '0, sample_out;
  logic              sample_in_valid = 1'b1, sample_is_8bit = 1'b0, timestamp_pin = 1'b0;
  logic [7:0]        k_from_mode_m1 = 8'h3C, link_mode_select, frames_per_multiframe_eff;
  logic              sample_out_valid, dither_enable, dither_amplitude_sel;
  logic              dither_round_error_sel, timestamp_receiver_enable, cal_enable;
  logic              link_block_reset, serializer_power_down, link_clock_enable;
  logic              multiframe_counter_reset;
  int                failures = 0;
  int                checks_done = 0;

  always #2.5 clk = ~clk;

  adc_dither_timestamp_link_ctrl adc_dither_timestamp_link_ctrl_inst (.*);

  // ************************************************************
  // bus cycles and comparison
  // ************************************************************
  task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // byte address is worked out here, not through the package helper
  task automatic axi_write(input logic [11:0] idx, input logic [7:0] d, input logic [1:0] er);
    logic aw_done, w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    s_axi_awaddr <= {idx[9:0], 2'h0};
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge clk);
      if (!aw_done && s_axi_awready === 1'b1) begin
        aw_done = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w_done && s_axi_wready === 1'b1) begin
        w_done = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge clk); while (s_axi_bvalid !== 1'b1);
    check_val(s_axi_bresp, er);
    s_axi_bready <= 1'b0;
    // idle edge so a following call never re-raises a strobe in the same step
    @(posedge clk);
  endtask

  task automatic axi_read(input logic [11:0] idx, input logic [31:0] exp, input logic [1:0] er);
    s_axi_araddr <= {idx[9:0], 2'h0};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge clk); while (s_axi_rvalid !== 1'b1);
    check_val(s_axi_rdata, exp);
    check_val(s_axi_rresp, er);
    s_axi_rready <= 1'b0;
    @(posedge clk);
  endtask

  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic reset_values();
    axi_read(IDX_DITHER, 32'h01, RESP_OKAY);
    axi_read(IDX_TS_LSB, 32'h00, RESP_OKAY);
    axi_read(IDX_LINK_EN, 32'h01, RESP_OKAY);
    axi_read(IDX_LINK_MODE, 32'h02, RESP_OKAY);
    axi_read(IDX_KM, 32'h1F, RESP_OKAY);
    check_val(link_clock_enable, 1'b1);
    check_val(frames_per_multiframe_eff, 8'h1F);
    check_val(ila_control_bits, 2'h0);
  endtask

  task automatic dither_bits();
    axi_write(IDX_DITHER, 8'hFE, RESP_OKAY);
    axi_read(IDX_DITHER, 32'hFE, RESP_OKAY);
    check_val({dither_round_error_sel, dither_amplitude_sel, dither_enable}, 3'h6);
    axi_write(IDX_DITHER, 8'h01, RESP_OKAY);
    check_val({dither_round_error_sel, dither_amplitude_sel, dither_enable}, 3'h1);
  endtask

  task automatic link_off_and_mode();
    axi_write(IDX_MISC, 8'h03, RESP_OKAY);
    check_val(cal_enable, 1'b1);
    axi_write(IDX_LINK_EN, 8'h00, RESP_OKAY);
    check_val({link_block_reset, serializer_power_down}, 2'h3);
    check_val({link_clock_enable, multiframe_counter_reset}, 2'h1);
    axi_write(IDX_MISC, 8'h01, RESP_OKAY);
    axi_write(IDX_LINK_MODE, 8'h10, RESP_OKAY);
    check_val(link_mode_select, 8'h10);
    axi_write(IDX_MODE_LOCK, 8'h05, RESP_OKAY);
    axi_write(IDX_LINK_MODE, 8'h11, RESP_OKAY);
    axi_read(IDX_LINK_MODE, 32'h10, RESP_OKAY);
    axi_write(IDX_KM, 8'h0F, RESP_OKAY);
    check_val(frames_per_multiframe_eff, 8'h0F);
    axi_write(IDX_MODE_LOCK, 8'hFF, RESP_OKAY);
    axi_write(IDX_LINK_MODE, 8'h20, RESP_OKAY);
    check_val(frames_per_multiframe_eff, 8'h3C);
    axi_write(IDX_MISC, 8'h03, RESP_OKAY);
    axi_write(IDX_LINK_EN, 8'h01, RESP_OKAY);
    check_val({link_block_reset, link_clock_enable}, 2'h1);
    check_val({serializer_power_down, multiframe_counter_reset}, 2'h0);
    axi_read(IDX_STATUS, 32'h05, RESP_OKAY);
    axi_write(12'h3FF, 8'h55, RESP_SLVERR);
    axi_read(12'h3FF, 32'h0, RESP_SLVERR);
  endtask

  // output of cycle k-1 is seen at edge k; a sample of cycle n leaves at cycle n+7
  task automatic sample_run(input logic is8, input logic tsen);
    logic [11:0] hist [0:31];
    logic        mark [0:31];
    logic [11:0] exp;
    logic [7:0]  k8;
    axi_write(IDX_TS_LSB, {7'h0, tsen}, RESP_OKAY);
    check_val(timestamp_receiver_enable, 1'b1);
    sample_is_8bit <= is8;
    repeat (10) @(posedge clk);
    for (int k = 0; k < 32; k++) begin
      @(posedge clk);
      k8 = k[7:0];
      if (k >= 8) begin
        exp = is8 ? {4'h0, hist[k-8][7:0]} : hist[k-8];
        if (tsen) exp[0] = mark[k-8];
        check_val(sample_out, exp);
        check_val(sample_out_valid, 1'b1);
      end
      hist[k] = 12'hA5B ^ {k8[3:0], k8};
      mark[k] = k8[0] ^ k8[2];
      sample_in <= hist[k];
      timestamp_pin <= mark[k];
    end
  endtask

  // ************************************************************
  // run control
  // ************************************************************
  task automatic tally_and_finish();
    if (failures == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    reset_values();
    dither_bits();
    link_off_and_mode();
    sample_run(1'b0, 1'b1);
    sample_run(1'b1, 1'b1);
    sample_run(1'b0, 1'b0);
    tally_and_finish();
  end

  // the whole run needs well under two thousand cycles
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    tally_and_finish();
  end

endmodule
